// ---- rsu_asserts.sv ----
// Port checker for the rotate and shift unit
`timescale 1ns/10ps
`default_nettype none
module rsu_asserts (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // APB and status
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_busy
);
  logic [15:0] instr_q;
  logic [4:0] cnt_q;
  wire acc = i_psel && i_penable;
  wire rd = acc && !i_pwrite;
  wire bad = i_paddr[1:0] != 2'h0 || i_paddr > 8'h1C;
  wire start = acc && i_pwrite && i_paddr == 8'h04 && i_pwdata[0];
  // Busy is sampled high one edge fewer than the state count
  wire [4:0] exp_t = instr_q[7:0] != 8'hCB ? 5'h16 : instr_q[10:8] == 3'h6 ? 5'h0E : 5'h07;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // Opcode writes during an operation are dropped by the unit
  always @(posedge i_mclk) begin
    if (i_srst) begin
      instr_q <= 16'h0000;
      cnt_q <= 5'h00;
    end else begin
      if (acc && i_pwrite && i_paddr == 8'h00 && !o_busy) begin
        instr_q <= i_pwdata[15:0];
      end
      cnt_q <= o_busy ? cnt_q + 5'h01 : 5'h00;
    end
  end
  AST_PREADY: assert property (acc |-> o_pready)
    else $error("access without ready");
  AST_SLVERR: assert property (acc |-> o_pslverr == bad)
    else $error("slave error does not match map");
  AST_BAD_READ: assert property (rd && bad |-> o_prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_START: assert property ($rose(o_busy) |-> $past(start))
    else $error("busy without start");
  AST_MIN_BUSY: assert property ($rose(o_busy) |-> o_busy[*7])
    else $error("operation too short");
  AST_LENGTH: assert property ($fell(o_busy) |-> cnt_q == exp_t)
    else $error("wrong state count");
  AST_STAT_BUSY: assert property (rd && i_paddr == 8'h1C |-> o_prdata[0] == o_busy)
    else $error("status busy bit wrong");
  AST_STAT_CYC: assert property (rd && i_paddr == 8'h1C && o_prdata[1] && !o_busy
    |-> {o_prdata[10:8], o_prdata[15:11]} inside {8'h48, 8'h8F, 8'hD7})
    else $error("status cycle counts wrong");
endmodule
bind rsu_rotate_shift rsu_asserts rsu_asserts_inst (.i_mclk(i_mclk), .i_srst(i_srst),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_busy(o_busy));
`default_nettype wire

// ---- rsu_defs.vh ----
// Constants for the rotate and shift unit
`ifndef RSU_DEFS_VH
`define RSU_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RSU_OFF_INSTR 8'h00
`define RSU_OFF_CTRL 8'h04
`define RSU_OFF_BCDE 8'h08
`define RSU_OFF_HLAF 8'h0C
`define RSU_OFF_IDX 8'h10
`define RSU_OFF_MADDR 8'h14
`define RSU_OFF_MDATA 8'h18
`define RSU_OFF_STAT 8'h1C

// ----------------------------------------
// Opcode bytes and fields
// ----------------------------------------
`define RSU_PFX_BITOP 8'hCB
`define RSU_PFX_IDX_X 8'hDD
`define RSU_PFX_IDX_Y 8'hFD
`define RSU_OP_RRC 5'h03
`define RSU_OP_ASL 5'h04
`define RSU_OP_ASR 5'h05
`define RSU_OP_LSR 5'h07
`define RSU_SEL_MEM 3'h6

// ----------------------------------------
// Clock states (one state per clock) and machine cycles per form
// ----------------------------------------
`define RSU_T_REG 5'h08
`define RSU_T_PTR 5'h0F
`define RSU_T_IDX 5'h17
`define RSU_M_REG 3'h2
`define RSU_M_PTR 3'h4
`define RSU_M_IDX 3'h6

// ----------------------------------------
// Flag bit positions
// ----------------------------------------
`define RSU_F_S 7
`define RSU_F_Z 6
`define RSU_F_H 4
`define RSU_F_PV 2
`define RSU_F_N 1
`define RSU_F_C 0

// ----------------------------------------
// Sizes, reset values and control and status bit positions
// ----------------------------------------
`define RSU_MEM_DEPTH 256
`define RSU_RST_BYTE 8'h00
`define RSU_RST_WORD 32'h00000000
`define RSU_CTRL_START 0
`define RSU_ST_BUSY 0
`define RSU_ST_DONE 1
`define RSU_ST_ERR 2

`endif

// ---- rsu_rotate_shift.v ----
// Rotate and shift datapath with APB register access
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "rsu_defs.vh"

module rsu_rotate_shift (
  // Clock and reset
  input wire i_mclk,
  input wire i_srst,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  // Status
  output reg o_busy
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_WB = 3'b100;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [7:0] gpr_q [0:7];
  // Memory keeps its contents through reset; software loads it first
  reg [7:0] mem_q [0:`RSU_MEM_DEPTH-1];
  reg [31:0] instr_q;
  reg [7:0] flags_q;
  reg [15:0] idx_x_q;
  reg [15:0] idx_y_q;
  reg [7:0] maddr_q;
  reg [2:0] state_q;
  reg [4:0] tcnt_q;
  reg [4:0] tlen_q;
  reg [2:0] mcyc_q;
  reg [7:0] opnd_q;
  reg [4:0] op_q;
  reg [2:0] sel_q;
  reg is_mem_q;
  reg [15:0] addr_q;
  reg done_q;
  reg err_q;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire bus_acc = i_psel & i_penable;
  wire bus_wr = bus_acc & i_pwrite;
  reg addr_ok;

  assign o_pready = 1'b1;
  assign o_pslverr = bus_acc & ~addr_ok;

  always @* begin
    case (i_paddr)
      `RSU_OFF_INSTR: addr_ok = 1'b1;
      `RSU_OFF_CTRL: addr_ok = 1'b1;
      `RSU_OFF_BCDE: addr_ok = 1'b1;
      `RSU_OFF_HLAF: addr_ok = 1'b1;
      `RSU_OFF_IDX: addr_ok = 1'b1;
      `RSU_OFF_MADDR: addr_ok = 1'b1;
      `RSU_OFF_MDATA: addr_ok = 1'b1;
      `RSU_OFF_STAT: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  wire [7:0] b0 = instr_q[7:0];
  wire [7:0] b1 = instr_q[15:8];
  wire [7:0] b2 = instr_q[23:16];
  wire [7:0] b3 = instr_q[31:24];
  wire form_cb = (b0 == `RSU_PFX_BITOP);
  wire form_idx = ((b0 == `RSU_PFX_IDX_X) | (b0 == `RSU_PFX_IDX_Y))
                  & (b1 == `RSU_PFX_BITOP);
  wire [7:0] dec_op_byte = form_idx ? b3 : b1;
  wire [4:0] dec_op = dec_op_byte[7:3];
  wire [2:0] dec_sel = dec_op_byte[2:0];
  wire op_known = (dec_op == `RSU_OP_RRC) | (dec_op == `RSU_OP_ASL) |
                  (dec_op == `RSU_OP_ASR) | (dec_op == `RSU_OP_LSR);
  // Indexed forms only exist with the memory selector
  wire dec_ok = op_known &
                (form_cb | (form_idx & (dec_sel == `RSU_SEL_MEM)));
  wire dec_mem = form_idx | (dec_sel == `RSU_SEL_MEM);
  wire [15:0] ptr_pair = {gpr_q[4], gpr_q[5]};
  wire [15:0] idx_base = (b0 == `RSU_PFX_IDX_Y) ? idx_y_q : idx_x_q;
  wire [15:0] disp_ext = {{8{b2[7]}}, b2};
  wire [15:0] idx_addr = idx_base + disp_ext;
  wire [15:0] dec_addr = form_idx ? idx_addr : ptr_pair;
  wire [4:0] dec_tlen = form_idx ? `RSU_T_IDX :
                        (dec_mem ? `RSU_T_PTR : `RSU_T_REG);
  wire [2:0] dec_mlen = form_idx ? `RSU_M_IDX :
                        (dec_mem ? `RSU_M_PTR : `RSU_M_REG);
  wire [7:0] dec_opnd = dec_mem ? mem_q[dec_addr[7:0]] : gpr_q[dec_sel];

  // ----------------------------------------
  // Shifter and flags
  // ----------------------------------------
  reg [7:0] res;
  reg res_c;
  wire old_c = flags_q[`RSU_F_C];

  // ----------------------------------------
  // Per-bit shift network
  // ----------------------------------------
  // Top bit of a right move depends on the operation
  reg shr_fill;
  wire [7:0] shr_bits;
  wire [7:0] shl_bits;
  genvar gi;
  always @* begin
    case (op_q)
      `RSU_OP_RRC: shr_fill = old_c;
      `RSU_OP_ASR: shr_fill = opnd_q[7];
      default: shr_fill = 1'b0;
    endcase
  end
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_bit
      // Right move takes the neighbour above, left move the one below
      if (gi == 7) begin : g_top
        assign shr_bits[gi] = shr_fill;
      end else begin : g_mid
        assign shr_bits[gi] = opnd_q[gi + 1];
      end
      if (gi == 0) begin : g_low
        assign shl_bits[gi] = 1'b0;
      end else begin : g_up
        assign shl_bits[gi] = opnd_q[gi - 1];
      end
    end
  endgenerate

  // Even parity of the result drives the parity-overflow flag
  wire [7:0] par_chain;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_par
      if (gi == 0) begin : g_first
        assign par_chain[gi] = res[gi];
      end else begin : g_next
        assign par_chain[gi] = par_chain[gi - 1] ^ res[gi];
      end
    end
  endgenerate

  // Carry takes the bit that falls off the end
  always @* begin
    case (op_q)
      `RSU_OP_RRC: begin
        res = shr_bits;
        res_c = opnd_q[0];
      end
      `RSU_OP_ASL: begin
        res = shl_bits;
        res_c = opnd_q[7];
      end
      `RSU_OP_ASR: begin
        res = shr_bits;
        res_c = opnd_q[0];
      end
      `RSU_OP_LSR: begin
        res = shr_bits;
        res_c = opnd_q[0];
      end
      default: begin
        res = opnd_q;
        res_c = old_c;
      end
    endcase
  end

  reg [7:0] new_flags;
  always @* begin
    // Bits 5 and 3 pass through untouched
    new_flags = flags_q;
    new_flags[`RSU_F_S] = res[7];
    new_flags[`RSU_F_Z] = (res == `RSU_RST_BYTE);
    new_flags[`RSU_F_H] = 1'b0;
    new_flags[`RSU_F_PV] = ~par_chain[7];
    new_flags[`RSU_F_N] = 1'b0;
    new_flags[`RSU_F_C] = res_c;
  end

  // ----------------------------------------
  // Sequencer and register file
  // ----------------------------------------
  wire start = bus_wr & (i_paddr == `RSU_OFF_CTRL) & i_pwdata[`RSU_CTRL_START];
  // Software writes to operands are dropped while an operation runs
  wire sw_wr_ok = bus_wr & (state_q == ST_IDLE);
  integer k;

  always @(posedge i_mclk) begin
    if (i_srst) begin
      state_q <= ST_IDLE;
      instr_q <= `RSU_RST_WORD;
      flags_q <= `RSU_RST_BYTE;
      idx_x_q <= 16'h0000;
      idx_y_q <= 16'h0000;
      maddr_q <= `RSU_RST_BYTE;
      tcnt_q <= 5'h00;
      tlen_q <= 5'h00;
      mcyc_q <= 3'h0;
      opnd_q <= `RSU_RST_BYTE;
      op_q <= 5'h00;
      sel_q <= 3'h0;
      is_mem_q <= 1'b0;
      addr_q <= 16'h0000;
      done_q <= 1'b0;
      err_q <= 1'b0;
      o_busy <= 1'b0;
      for (k = 0; k < 8; k = k + 1) begin
        gpr_q[k] <= `RSU_RST_BYTE;
      end
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            done_q <= 1'b0;
            if (dec_ok) begin
              op_q <= dec_op;
              sel_q <= dec_sel;
              is_mem_q <= dec_mem;
              addr_q <= dec_addr;
              opnd_q <= dec_opnd;
              tlen_q <= dec_tlen;
              mcyc_q <= dec_mlen;
              tcnt_q <= 5'h01;
              err_q <= 1'b0;
              o_busy <= 1'b1;
              state_q <= ST_RUN;
            end else begin
              err_q <= 1'b1;
            end
          end
        end
        ST_RUN: begin
          // Last state is spent on the write back
          tcnt_q <= tcnt_q + 5'h01;
          if (tcnt_q == tlen_q - 5'h02) begin
            state_q <= ST_WB;
          end
        end
        ST_WB: begin
          // Result and flags land on the same edge that drops busy
          if (is_mem_q) begin
            mem_q[addr_q[7:0]] <= res;
          end else begin
            gpr_q[sel_q] <= res;
          end
          flags_q <= new_flags;
          tcnt_q <= tcnt_q + 5'h01;
          done_q <= 1'b1;
          o_busy <= 1'b0;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
          o_busy <= 1'b0;
        end
      endcase

      // Software writes; never in the same cycle as a write back
      if (sw_wr_ok) begin
        case (i_paddr)
          `RSU_OFF_INSTR: instr_q <= i_pwdata;
          `RSU_OFF_BCDE: begin
            gpr_q[0] <= i_pwdata[31:24];
            gpr_q[1] <= i_pwdata[23:16];
            gpr_q[2] <= i_pwdata[15:8];
            gpr_q[3] <= i_pwdata[7:0];
          end
          `RSU_OFF_HLAF: begin
            gpr_q[4] <= i_pwdata[31:24];
            gpr_q[5] <= i_pwdata[23:16];
            gpr_q[7] <= i_pwdata[15:8];
            flags_q <= i_pwdata[7:0];
          end
          `RSU_OFF_IDX: begin
            idx_y_q <= i_pwdata[31:16];
            idx_x_q <= i_pwdata[15:0];
          end
          `RSU_OFF_MADDR: maddr_q <= i_pwdata[7:0];
          `RSU_OFF_MDATA: mem_q[maddr_q] <= i_pwdata[7:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  // Address byte and counts keep the last operation's values until the next start
  wire [7:0] stat_lo = {5'h00, err_q, done_q, o_busy};
  wire [31:0] stat_word = {8'h00, addr_q[7:0], tcnt_q, mcyc_q, stat_lo};
  // Only the low address byte reaches the 256-byte array
  wire [7:0] mdata_rd = mem_q[maddr_q];

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always @* begin
    case (i_paddr)
      `RSU_OFF_INSTR: o_prdata = instr_q;
      `RSU_OFF_BCDE: o_prdata = {gpr_q[0], gpr_q[1], gpr_q[2], gpr_q[3]};
      `RSU_OFF_HLAF: o_prdata = {gpr_q[4], gpr_q[5], gpr_q[7], flags_q};
      `RSU_OFF_IDX: o_prdata = {idx_y_q, idx_x_q};
      `RSU_OFF_MADDR: o_prdata = {24'h000000, maddr_q};
      `RSU_OFF_MDATA: o_prdata = {24'h000000, mdata_rd};
      `RSU_OFF_STAT: o_prdata = stat_word;
      default: o_prdata = `RSU_RST_WORD;
    endcase
  end

endmodule
`default_nettype wire

// ---- test_rotate_shift_unit.sv ----
// Self-checking bench for the rotate and shift unit
`timescale 1ns/10ps
`default_nettype none
module test_rotate_shift_unit;
  logic i_mclk = 1'h0;
  logic i_srst = 1'h1;
  logic i_psel = 1'h0;
  logic i_penable = 1'h0;
  logic i_pwrite = 1'h0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  wire [31:0] o_prdata;
  wire o_pready;
  wire o_pslverr;
  wire o_busy;
  int fail_count = 0;
  int checked = 0;
  logic [31:0] rd;
  logic [7:0] vt [8] = '{8'h01, 8'h80, 8'hDD, 8'hB1, 8'h8F, 8'h00, 8'hB8, 8'h7E};
  logic [4:0] ops [4] = '{5'h03, 5'h04, 5'h05, 5'h07};
  rsu_rotate_shift rsu_rotate_shift_inst (.i_mclk(i_mclk), .i_srst(i_srst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_busy(o_busy));
  initial begin
    forever #2 i_mclk = ~i_mclk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Read data is taken at the edge where ready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_psel <= 1'h1;
    i_penable <= 1'h0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'h1;
    do @(posedge i_mclk); while (o_pready !== 1'h1);
    rd = o_prdata;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    @(posedge i_mclk);
  endtask
  task automatic poll();
    int n;
    n = 0;
    do begin
      apb(1'h0, 8'h1C, 32'h0);
      n++;
    end while (rd[0] !== 1'h0 && n < 20);
  endtask
  // Returns carry above the result byte
  function automatic logic [8:0] calc(input logic [4:0] op, input logic [7:0] v, input logic c);
    case (op)
      5'h03: calc = {v[0], c, v[7:1]};
      5'h04: calc = {v[7], v[6:0], 1'h0};
      5'h05: calc = {v[0], v[7], v[7:1]};
      default: calc = {v[0], 1'h0, v[7:1]};
    endcase
  endfunction
  task automatic run(input logic [4:0] op, input logic [2:0] s, input logic [1:0] ix,
      input logic [7:0] v, input logic c, input logic [7:0] d);
    logic [7:0] r [8];
    logic [7:0] ea;
    logic [8:0] x;
    logic [4:0] t;
    logic [2:0] m;
    int n;
    for (n = 0; n < 8; n++) r[n] = 8'(n * 29 + 64);
    r[s] = v;
    x = calc(op, v, c);
    ea = ix == 2'h0 ? r[5] : (ix == 2'h1 ? 8'h80 : 8'hF0) + d;
    t = s != 3'h6 ? 5'h08 : ix == 2'h0 ? 5'h0F : 5'h17;
    m = s != 3'h6 ? 3'h2 : ix == 2'h0 ? 3'h4 : 3'h6;
    apb(1'h1, 8'h08, {r[0], r[1], r[2], r[3]});
    apb(1'h1, 8'h0C, {r[4], r[5], r[7], 7'h7F, c});
    apb(1'h1, 8'h10, 32'h20F01080);
    apb(1'h1, 8'h14, {24'h0, ea});
    apb(1'h1, 8'h18, {24'h0, v});
    if (ix == 2'h0) apb(1'h1, 8'h00, {16'h0, op, s, 8'hCB});
    else apb(1'h1, 8'h00, {op, s, d, 8'hCB, ix[0] ? 8'hDD : 8'hFD});
    apb(1'h1, 8'h04, 32'h1);
    poll();
    chk("status", {8'h0, m == 3'h2 ? 8'h0 : ea, t, m, 8'h02},
      {8'h0, m == 3'h2 ? 8'h0 : rd[23:16], rd[15:0]});
    apb(1'h0, 8'h0C, 32'h0);
    chk("flags", {24'h0, x[7] & (op != 5'h07), x[7:0] == 8'h0, 3'h5, ~^x[7:0], 1'h0, x[8]},
      {24'h0, rd[7:0]});
    if (s == 3'h6) begin
      apb(1'h1, 8'h14, {24'h0, ea});
      apb(1'h0, 8'h18, 32'h0);
    end else apb(1'h0, s[2] ? 8'h0C : 8'h08, 32'h0);
    n = s == 3'h6 ? 0 : s == 3'h7 ? 1 : 3 - s[1:0];
    chk("result", {24'h0, x[7:0]}, {24'h0, rd[8 * n +: 8]});
  endtask
  // Writes during an operation and a malformed indexed opcode must both be ignored
  task automatic refuse();
    apb(1'h1, 8'h08, 32'h8F000000);
    apb(1'h1, 8'h00, 32'h000038CB);
    apb(1'h1, 8'h04, 32'h1);
    apb(1'h1, 8'h08, 32'h0);
    poll();
    apb(1'h0, 8'h08, 32'h0);
    chk("busy write", 32'h47000000, rd);
    apb(1'h1, 8'h00, 32'h1805CBDD);
    apb(1'h1, 8'h04, 32'h1);
    apb(1'h0, 8'h1C, 32'h0);
    chk("bad form", 32'h4, {29'h0, rd[2], 1'h0, rd[0]});
  endtask
  initial begin
    repeat (3) @(posedge i_mclk);
    i_srst <= 1'h0;
    @(posedge i_mclk);
    for (int a = 4; a < 36; a += 4) begin
      apb(1'h0, 8'(a), 32'h0);
      if (a != 24) chk("reset read", 32'h0, rd);
    end
    for (int k = 0; k < 4; k++) begin
      for (int s = 0; s < 8; s++) run(ops[k], 3'(s), 2'h0, vt[s], s[0], 8'h00);
      run(ops[k], 3'h6, 2'h1, vt[k], 1'h1, 8'hF8);
      run(ops[k], 3'h6, 2'h2, vt[k + 4], 1'h0, 8'h13);
    end
    refuse();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge i_mclk);
    fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
